/* logic/cfg_header_regs.v */
// Configuration header registers from the self-test byte to the latency byte.
`timescale 1ns/1ps
`include "cfg_header_regs_defines.vh"

module cfg_header_regs #(
  // Arbitrary values, used only while no EEPROM supplies the codes.
  parameter [15:0] SUB_VENDOR_DEFAULT = 16'h1234,
  parameter [15:0] SUB_ID_DEFAULT     = 16'h5678
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Configuration access
  input  wire [5:0]  cfgAddr,
  input  wire        cfgRead,
  input  wire        cfgWrite,
  input  wire [3:0]  cfgByteEn,
  input  wire [31:0] cfgWriteData,
  output reg  [31:0] cfgReadData,
  output reg         cfgReadValid,
  // Settings held in other configuration registers
  input  wire [2:0]  bootRomSizeCode,
  input  wire        cardBusEnable,
  // EEPROM auto-load
  input  wire        eeWordValid,
  input  wire [2:0]  eeWordSel,
  input  wire [15:0] eeWordData,
  input  wire        eeLoadDone,
  input  wire        eeAbsent,
  // Decoded state for the rest of the device
  output reg  [23:0] ioBaseBits,
  output reg  [23:0] memBaseBits,
  output reg  [13:0] bootRomBaseBits,
  output reg         bootRomEnable,
  output reg  [7:0]  interruptLine,
  output reg         cisPointerValid,
  output reg         cisInMemory,
  output reg         regsLoaded
);

  // Writable bits of the boot ROM base register for a size code.
  // Codes six and seven are unused and behave like no ROM at all.
  function [31:0] romWriteMask;
    input [2:0] code;
    reg   [31:0] lowBits;
    begin
      lowBits = 32'h0000_0000;
      if (code != `ROM_CODE_NONE && code <= `ROM_CODE_MAX) begin
        lowBits = (32'h0000_0001 << (`ROM_MIN_SHIFT + code)) - 32'h0000_0001;
        romWriteMask = ~lowBits | 32'h0000_0001;
      end else begin
        romWriteMask = 32'h0000_0000;
      end
    end
  endfunction

  // Byte-lane merge of a write into a register, limited to writable bits.
  // Bits outside the mask keep their stored value even in an enabled lane.
  function [31:0] mergeWrite;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  byteEn;
    input [31:0] mask;
    integer      i;
    reg   [31:0] laneMask;
    begin
      laneMask = 32'h0000_0000;
      for (i = 0; i < 4; i = i + 1) begin
        if (byteEn[i]) begin
          laneMask[i*8 +: 8] = 8'hFF;
        end
      end
      laneMask = laneMask & mask;
      mergeWrite = (newVal & laneMask) | (oldVal & ~laneMask);
    end
  endfunction

  // A pointer space code of zero is unsupported and never marks the
  // pointer valid.
  function spaceUsable;
    input [2:0] space;
    begin
      spaceUsable = (space != `CIS_SPACE_NONE);
    end
  endfunction

  // Codes one to six point into memory behind a base register; seven
  // points into the expansion ROM instead.
  function spaceIsMemory;
    input [2:0] space;
    begin
      spaceIsMemory = spaceUsable(space) && (space != `CIS_SPACE_ROM);
    end
  endfunction

  // Software-visible storage
  reg  [31:0] ioBase_q;
  reg  [31:0] ioBase_d;
  reg  [31:0] memBase_q;
  reg  [31:0] memBase_d;
  reg  [31:0] romBase_q;
  reg  [31:0] romBase_d;
  reg  [7:0]  intLine_q;
  reg  [7:0]  intLine_d;

  // EEPROM-sourced values as seen by software
  reg  [31:0] card_info_pointer_q;
  reg  [15:0] subVendor_q;
  reg  [15:0] subId_q;
  reg  [7:0]  minGrant_q;
  reg  [7:0]  maxLat_q;

  // Staging area filled word by word during the auto-load
  reg  [31:0] cisStage_q;
  reg  [15:0] subVendorStage_q;
  reg  [15:0] subIdStage_q;
  reg  [7:0]  minGrantStage_q;
  reg  [7:0]  maxLatStage_q;
  reg         loaded_q;

  reg  [31:0] readData_d;
  wire [31:0] romMask;
  wire [31:0] romView;
  wire [2:0]  cisSpace;
  wire        writeHit;

  // Size code and card-bus enable are levels owned by other configuration
  // registers; a change shows on the very next read.
  assign romMask  = romWriteMask(bootRomSizeCode);
  // Stored bits outside the current mask read zero, so enlarging the
  // ROM size later hides stale address bits without a rewrite.
  assign romView  = romBase_q & romMask;
  assign cisSpace = card_info_pointer_q[2:0];
  assign writeHit = cfgWrite;

  // Write path
  // Writes to dwords not listed fall through and leave all storage alone.
  always @* begin
    ioBase_d  = ioBase_q;
    memBase_d = memBase_q;
    romBase_d = romBase_q;
    intLine_d = intLine_q;
    if (writeHit) begin
      case (cfgAddr)
        `IO_BASE_DW: begin
          ioBase_d = mergeWrite(ioBase_q, cfgWriteData, cfgByteEn,
                                `IO_WRITE_MASK);
        end
        `MEM_BASE_DW: begin
          memBase_d = mergeWrite(memBase_q, cfgWriteData, cfgByteEn,
                                 `MEM_WRITE_MASK);
        end
        `BOOT_ROM_DW: begin
          // Address bits below the ROM size and the reserved bits are
          // outside the mask, so they keep their stored value whatever is written.
          romBase_d = mergeWrite(romBase_q, cfgWriteData, cfgByteEn,
                                 romMask);
        end
        `INTERRUPT_DW: begin
          // Only the low lane holds the line byte; the pin and timer
          // bytes above it are read-only and ignore the write.
          if (cfgByteEn[0]) begin
            intLine_d = cfgWriteData[7:0];
          end
        end
        default: begin
          // Self-test, pointer, subsystem and timer bytes ignore writes.
          intLine_d = intLine_q;
        end
      endcase
    end
  end

  // Read path
  always @* begin
    readData_d = 32'h0000_0000;
    case (cfgAddr)
      `SELF_TEST_DW: begin
        // The other bytes of this dword belong to registers kept
        // elsewhere and read zero from this block.
        readData_d = {`SELF_TEST_VALUE, 24'h00_0000};
      end
      `IO_BASE_DW: begin
        // Reserved bit 1 falls out of both the mask and the fixed bits.
        readData_d = (ioBase_q & `IO_WRITE_MASK) |
                     `IO_READ_FIXED;
      end
      `MEM_BASE_DW: begin
        // Size, prefetch, location and space bits are all fixed zero.
        readData_d = (memBase_q & `MEM_WRITE_MASK) |
                     `MEM_READ_FIXED;
      end
      `CARD_INFO_DW: begin
        // The pointer is hidden while card-bus support is off, so that
        // software never follows a value it should ignore.
        readData_d = cardBusEnable ? card_info_pointer_q : 32'h0000_0000;
      end
      `SUBSYSTEM_DW: begin
        readData_d = {subId_q, subVendor_q};
      end
      `BOOT_ROM_DW: begin
        readData_d = romView;
      end
      `INTERRUPT_DW: begin
        // The pin byte is fixed; the timers come from the committed load.
        readData_d = {maxLat_q, minGrant_q,
                      `IRQ_PIN_VALUE, intLine_q};
      end
      default: begin
        readData_d = 32'h0000_0000;
      end
    endcase
  end

  // Register storage and registered read answer
  // Read data is held until the next read, so a host that samples late
  // still sees the answer it asked for.
  always @(posedge clk) begin
    if (reset) begin
      ioBase_q     <= `BASE_RESET;
      memBase_q    <= `BASE_RESET;
      romBase_q    <= `BASE_RESET;
      intLine_q    <= `IRQ_LINE_RESET;
      cfgReadData  <= 32'h0000_0000;
      cfgReadValid <= 1'b0;
    end else begin
      ioBase_q     <= ioBase_d;
      memBase_q    <= memBase_d;
      romBase_q    <= romBase_d;
      intLine_q    <= intLine_d;
      cfgReadValid <= cfgRead;
      if (cfgRead) begin
        cfgReadData <= readData_d;
      end
    end
  end

  // EEPROM staging; words land here and stay invisible until commit.
  // Words may come in any order; a repeated selector overwrites the last.
  always @(posedge clk) begin
    if (reset) begin
      cisStage_q       <= `CIS_DEFAULT;
      subVendorStage_q <= SUB_VENDOR_DEFAULT;
      subIdStage_q     <= SUB_ID_DEFAULT;
      minGrantStage_q  <= `MIN_GRANT_DEFAULT;
      maxLatStage_q    <= `MAX_LAT_DEFAULT;
    end else if (eeWordValid) begin
      case (eeWordSel)
        `EE_SEL_CIS_LOW: begin
          cisStage_q[15:0] <= eeWordData;
        end
        `EE_SEL_CIS_HIGH: begin
          cisStage_q[31:16] <= eeWordData;
        end
        `EE_SEL_SUB_VENDOR: begin
          subVendorStage_q <= eeWordData;
        end
        `EE_SEL_SUB_ID: begin
          subIdStage_q <= eeWordData;
        end
        `EE_SEL_TIMERS: begin
          minGrantStage_q <= eeWordData[7:0];
          maxLatStage_q   <= eeWordData[15:8];
        end
        default: begin
          minGrantStage_q <= minGrantStage_q;
        end
      endcase
    end
  end

  // Commit of the loaded values. An absent EEPROM keeps the defaults
  // but still marks the header as settled. Absence wins over a commit in
  // the same cycle, because the staged words cannot be trusted then.
  always @(posedge clk) begin
    if (reset) begin
      card_info_pointer_q    <= `CIS_DEFAULT;
      subVendor_q <= SUB_VENDOR_DEFAULT;
      subId_q     <= SUB_ID_DEFAULT;
      minGrant_q  <= `MIN_GRANT_DEFAULT;
      maxLat_q    <= `MAX_LAT_DEFAULT;
      loaded_q    <= 1'b0;
    end else if (eeAbsent) begin
      loaded_q <= 1'b1;
    end else if (eeLoadDone) begin
      card_info_pointer_q    <= cisStage_q;
      subVendor_q <= subVendorStage_q;
      subId_q     <= subIdStage_q;
      minGrant_q  <= minGrantStage_q;
      maxLat_q    <= maxLatStage_q;
      loaded_q    <= 1'b1;
    end
  end

  // Decoded outputs, each held in a flip-flop.
  // They lag the storage by one cycle; the rest of the device must not
  // expect a configuration write to act on the same edge.
  always @(posedge clk) begin
    if (reset) begin
      ioBaseBits      <= 24'h00_0000;
      memBaseBits     <= 24'h00_0000;
      bootRomBaseBits <= 14'h0000;
      bootRomEnable   <= 1'b0;
      interruptLine   <= 8'h00;
      cisPointerValid <= 1'b0;
      cisInMemory     <= 1'b0;
      regsLoaded      <= 1'b0;
    end else begin
      ioBaseBits      <= ioBase_q[31:8];
      memBaseBits     <= memBase_q[31:8];
      bootRomBaseBits <= romView[31:`ROM_BASE_LSB];
      bootRomEnable   <= romView[`ROM_ENABLE_BIT];
      interruptLine   <= intLine_q;
      cisPointerValid <= cardBusEnable && loaded_q &&
                         spaceUsable(cisSpace);
      // A memory-space pointer is only taken as such when its offset
      // starts at the auto-loaded structure, 100h or above.
      cisInMemory     <= cardBusEnable && loaded_q &&
                         spaceIsMemory(cisSpace) &&
                         (card_info_pointer_q[27:3] >= `CIS_MEM_OFFSET);
      regsLoaded      <= loaded_q;
    end
  end

endmodule

/* logic/cfg_header_regs_defines.vh */
// Offsets, field positions, reset values and codes of the configuration header registers.
`ifndef CFG_HEADER_REGS_DEFINES_VH
`define CFG_HEADER_REGS_DEFINES_VH

// Double-word indices of the configuration accesses (byte address / 4).
`define SELF_TEST_DW        6'h03
`define IO_BASE_DW          6'h04
`define MEM_BASE_DW         6'h05
`define CARD_INFO_DW        6'h0A
`define SUBSYSTEM_DW        6'h0B
`define BOOT_ROM_DW         6'h0C
`define INTERRUPT_DW        6'h0F

// Writable masks and fixed read bits of the base registers.
`define IO_WRITE_MASK       32'hFFFF_FF00
`define IO_READ_FIXED       32'h0000_0001
`define MEM_WRITE_MASK      32'hFFFF_FF00
`define MEM_READ_FIXED      32'h0000_0000

// Boot ROM base register fields and size codes.
`define ROM_BASE_LSB        18
`define ROM_SIZE_LSB        11
`define ROM_ENABLE_BIT      0
`define ROM_MIN_SHIFT       12
`define ROM_CODE_NONE       3'h0
`define ROM_CODE_MAX        3'h5

// Card information pointer fields.
`define CIS_SPACE_NONE      3'h0
`define CIS_SPACE_ROM       3'h7
`define CIS_MEM_OFFSET      25'h000_0020
`define CIS_DEFAULT         32'h0000_0000

// Fixed and default values.
`define SELF_TEST_VALUE     8'h00
`define IRQ_PIN_VALUE       8'h01
`define IRQ_LINE_RESET      8'h00
`define MIN_GRANT_DEFAULT   8'h20
`define MAX_LAT_DEFAULT     8'h20
`define BASE_RESET          32'h0000_0000

// Selectors of the words delivered by the EEPROM auto-load.
`define EE_SEL_CIS_LOW      3'h0
`define EE_SEL_CIS_HIGH     3'h1
`define EE_SEL_SUB_VENDOR   3'h2
`define EE_SEL_SUB_ID       3'h3
`define EE_SEL_TIMERS       3'h4

`endif

/* verification/cfg_header_regs_sva.sv */
// Concurrent checks on the configuration header register ports.
`timescale 1ns/1ps
`include "cfg_header_regs_defines.vh"
module cfg_header_regs_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Configuration access
  input wire logic [5:0]  cfgAddr,
  input wire logic        cfgRead,
  input wire logic [31:0] cfgReadData,
  input wire logic        cfgReadValid,
  // Settings and auto-load
  input wire logic [2:0]  bootRomSizeCode,
  input wire logic        cardBusEnable,
  input wire logic        eeLoadDone,
  input wire logic        eeAbsent,
  // Decoded state
  input wire logic [13:0] bootRomBaseBits,
  input wire logic        bootRomEnable,
  input wire logic        cisPointerValid,
  input wire logic        cisInMemory,
  input wire logic        regsLoaded
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd(a);
    cfgRead && cfgAddr == a;
  endsequence
  chk_read_answer: assert property (cfgRead |=> cfgReadValid)
    else $error("read strobe got no answer");
  chk_no_spurious: assert property (!cfgRead |=> !cfgReadValid)
    else $error("answer without read strobe");
  chk_self_zero: assert property (
    s_rd(`SELF_TEST_DW) |=> cfgReadData == 32'h0000_0000)
    else $error("self-test byte not zero");
  chk_io_low: assert property (
    s_rd(`IO_BASE_DW) |=> cfgReadData[7:0] == 8'h01)
    else $error("io base low byte wrong");
  chk_mem_low: assert property (
    s_rd(`MEM_BASE_DW) |=> cfgReadData[7:0] == 8'h00)
    else $error("memory base low byte wrong");
  chk_pin_byte: assert property (
    s_rd(`INTERRUPT_DW) |=> cfgReadData[15:8] == 8'h01)
    else $error("interrupt pin byte wrong");
  chk_rom_none: assert property (
    (bootRomSizeCode == 3'h0)[*3] |-> !bootRomEnable
    && bootRomBaseBits == 14'h0000)
    else $error("boot rom active without size");
  chk_cis_gate: assert property (
    (!cardBusEnable)[*3] |-> !cisPointerValid)
    else $error("pointer valid while card bus off");
  chk_cis_memory: assert property (
    cisInMemory |-> regsLoaded && $past(cardBusEnable))
    else $error("memory pointer flagged without load or card bus");
  chk_load_rise: assert property (
    eeLoadDone && !eeAbsent |-> ##2 regsLoaded)
    else $error("loaded flag late after commit");
  chk_load_keep: assert property (regsLoaded |=> regsLoaded)
    else $error("loaded flag dropped");
endmodule
bind cfg_header_regs cfg_header_regs_sva i_chk (.clk, .reset, .cfgAddr,
  .cfgRead, .cfgReadData, .cfgReadValid, .bootRomSizeCode, .cardBusEnable,
  .eeLoadDone, .eeAbsent, .bootRomBaseBits, .bootRomEnable,
  .cisPointerValid, .cisInMemory, .regsLoaded);

/* verification/ee_load_model.sv */
// Serial EEPROM auto-load source feeding staged words and commit or absence pulses.
`timescale 1ns/1ps
module ee_load_model (
  // Clock
  input wire logic  clk,
  // Auto-load outputs
  output logic        eeWordValid,
  output logic [2:0]  eeWordSel,
  output logic [15:0] eeWordData,
  output logic        eeLoadDone,
  output logic        eeAbsent
);
  initial begin
    eeWordValid = 1'b0;
    eeWordSel = 3'h7;
    eeWordData = 16'h0000;
    eeLoadDone = 1'b0;
    eeAbsent = 1'b0;
  end
  // Idle lines show the inverse of the last word, so a late sample fails.
  task automatic put(input logic [2:0] s, input logic [15:0] d);
    @(negedge clk);
    eeWordSel = s;
    eeWordData = d;
    eeWordValid = 1'b1;
    @(negedge clk);
    eeWordValid = 1'b0;
    eeWordSel = ~s;
    eeWordData = ~d;
  endtask
  task automatic pulse(input logic absent);
    @(negedge clk);
    eeLoadDone = !absent;
    eeAbsent = absent;
    @(negedge clk);
    eeLoadDone = 1'b0;
    eeAbsent = 1'b0;
  endtask
endmodule

/* verification/tb_cfg_header_regs.sv */
// Self-checking bench for the configuration header registers.
`timescale 1ns/1ps
`include "cfg_header_regs_defines.vh"
module tb_cfg_header_regs;
  logic        clk, reset, cfgRead, cfgWrite, cardBusEnable, cfgReadValid;
  logic        eeWordValid, eeLoadDone, eeAbsent, bootRomEnable;
  logic        cisPointerValid, cisInMemory, regsLoaded;
  logic [2:0]  bootRomSizeCode, eeWordSel;
  logic [3:0]  cfgByteEn;
  logic [5:0]  cfgAddr;
  logic [7:0]  interruptLine;
  logic [13:0] bootRomBaseBits;
  logic [15:0] eeWordData;
  logic [23:0] ioBaseBits, memBaseBits;
  logic [31:0] cfgWriteData, cfgReadData;
  int          n_fail = 0, n_tests = 0;
  cfg_header_regs #(.SUB_VENDOR_DEFAULT(16'hA5C3),
    .SUB_ID_DEFAULT(16'h3C5A)) i_dut (.clk, .reset, .cfgAddr, .cfgRead,
    .cfgWrite, .cfgByteEn, .cfgWriteData, .cfgReadData, .cfgReadValid,
    .bootRomSizeCode, .cardBusEnable, .eeWordValid, .eeWordSel,
    .eeWordData, .eeLoadDone, .eeAbsent, .ioBaseBits, .memBaseBits,
    .bootRomBaseBits, .bootRomEnable, .interruptLine, .cisPointerValid,
    .cisInMemory, .regsLoaded);
  ee_load_model i_ee (.clk, .eeWordValid, .eeWordSel, .eeWordData,
    .eeLoadDone, .eeAbsent);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(negedge clk);
    cfgAddr = a;
    cfgByteEn = (d == 32'h0000_1200) ? 4'h2 : 4'hF;
    cfgWriteData = d;
    cfgWrite = 1'b1;
    @(negedge clk);
    cfgWrite = 1'b0;
  endtask
  // The valid flag stands only in the cycle after the strobe edge, so it is
  // judged at the falling edge inside that cycle.
  task automatic rd(input string nm, input logic [5:0] a, logic [31:0] e);
    @(negedge clk);
    cfgAddr = a;
    cfgRead = 1'b1;
    @(negedge clk);
    check("read valid", {31'h0, cfgReadValid}, 1);
    check(nm, cfgReadData, e);
    cfgRead = 1'b0;
  endtask
  task automatic t_defaults;
    rd("self test", `SELF_TEST_DW, 0);
    rd("io base", `IO_BASE_DW, 1);
    rd("subsystem", `SUBSYSTEM_DW, 32'h3C5A_A5C3);
    rd("timers", `INTERRUPT_DW, 32'h2020_0100);
    rd("unmapped", 6'h3F, 0);
    check("loaded", {31'h0, regsLoaded}, 0);
    $display("defaults done");
  endtask
  task automatic t_bases;
    wr(`SELF_TEST_DW, 32'hFFFF_FFFF);
    wr(`IO_BASE_DW, 32'hFFFF_FFFF);
    wr(`IO_BASE_DW, 32'h0000_1200);
    wr(`MEM_BASE_DW, 32'hFFFF_FFFF);
    wr(`INTERRUPT_DW, 32'hFFFF_FF5A);
    rd("self test", `SELF_TEST_DW, 0);
    rd("io base", `IO_BASE_DW, 32'hFFFF_1201);
    rd("mem base", `MEM_BASE_DW, 32'hFFFF_FF00);
    rd("irq", `INTERRUPT_DW, 32'h2020_015A);
    check("io bits", {8'h00, ioBaseBits}, 32'h00FF_FF12);
    check("mem bits", {8'h00, memBaseBits}, 32'h00FF_FFFF);
    check("line", {24'h0, interruptLine}, 32'h0000_005A);
    $display("bases done");
  endtask
  task automatic t_rom;
    logic [31:0] e;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      bootRomSizeCode = k[2:0];
      wr(`BOOT_ROM_DW, 32'hFFFF_FFFF);
      case (k)
        1: e = 32'hFFFF_E001;
        2: e = 32'hFFFF_C001;
        3: e = 32'hFFFF_8001;
        4: e = 32'hFFFF_0001;
        5: e = 32'hFFFE_0001;
        default: e = 32'h0000_0000;
      endcase
      rd("boot rom", `BOOT_ROM_DW, e);
      check("rom enable", {31'h0, bootRomEnable}, {31'h0, e[0]});
      check("rom bits", {18'h0, bootRomBaseBits}, {18'h0, e[31:18]});
    end
    $display("boot rom done");
  endtask
  task automatic t_eeprom;
    @(negedge clk);
    cardBusEnable = 1'b1;
    i_ee.put(3'h0, 16'h0102);
    i_ee.put(3'h1, 16'h0000);
    i_ee.put(3'h2, 16'hABCD);
    i_ee.put(3'h3, 16'h9876);
    i_ee.put(3'h4, 16'h3355);
    rd("staged", `SUBSYSTEM_DW, 32'h3C5A_A5C3);
    i_ee.pulse(1'b0);
    repeat (3) @(negedge clk);
    rd("cis", `CARD_INFO_DW, 32'h0000_0102);
    rd("subsystem", `SUBSYSTEM_DW, 32'h9876_ABCD);
    rd("timers", `INTERRUPT_DW, 32'h3355_015A);
    check("cis valid", {31'h0, cisPointerValid}, 1);
    check("cis mem", {31'h0, cisInMemory}, 1);
    check("loaded", {31'h0, regsLoaded}, 1);
    i_ee.put(3'h0, 16'h0007);
    i_ee.pulse(1'b0);
    repeat (3) @(negedge clk);
    rd("cis rom", `CARD_INFO_DW, 32'h0000_0007);
    check("cis rom valid", {31'h0, cisPointerValid}, 1);
    check("cis rom mem", {31'h0, cisInMemory}, 0);
    i_ee.put(3'h0, 16'h0100);
    i_ee.pulse(1'b0);
    repeat (3) @(negedge clk);
    check("cis none", {31'h0, cisPointerValid}, 0);
    @(negedge clk);
    cardBusEnable = 1'b0;
    rd("cis off", `CARD_INFO_DW, 0);
    check("cis valid", {31'h0, cisPointerValid}, 0);
    $display("eeprom done");
  endtask
  task automatic do_reset;
    @(negedge clk);
    reset = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
  endtask
  task automatic t_absent;
    do_reset;
    check("loaded", {31'h0, regsLoaded}, 0);
    i_ee.put(3'h2, 16'h1111);
    i_ee.pulse(1'b1);
    repeat (3) @(negedge clk);
    check("loaded", {31'h0, regsLoaded}, 1);
    rd("timers", `INTERRUPT_DW, 32'h2020_0100);
    rd("subsystem", `SUBSYSTEM_DW, 32'h3C5A_A5C3);
    rd("io base", `IO_BASE_DW, 1);
    $display("absent done");
  endtask
  initial begin
    reset = 1'b1;
    cfgRead = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 6'h00;
    cfgByteEn = 4'h0;
    cfgWriteData = 32'h0000_0000;
    bootRomSizeCode = 3'h0;
    cardBusEnable = 1'b0;
    do_reset;
    t_defaults;
    t_bases;
    t_rom;
    t_eeprom;
    t_absent;
    tally_and_finish;
  end
  initial begin
    #1_000_000;
    n_fail++;
    tally_and_finish;
  end
endmodule
